// >>> rdcal_pattern_gen.sv
// Read calibration pattern generator of one memory channel.
// ==============================================================
// Summary of operation
// RULE1 - Calibration command then second cycle sends first byte, then second byte.
// RULE2 - Burst data begins after the programmed read latency.
// RULE3 - Each byte goes out least significant bit first.
// RULE4 - Pattern bytes reset to 5Ah and 3Ch, inversion masks to 55h.
// RULE5 - Data pins with mask bit set carry the inverted pattern.
// RULE6 - Low mask drives data pins 0-7, high mask pins 8-15.
// RULE7 - Mask pins never carry an inverted pattern.
// RULE8 - No read bus inversion is applied during the calibration burst.
// RULE9 - Controller sends the second cycle right after the calibration command.
// RULE10 - Controller drives all second-cycle operand bits low.
// RULE11 - Back to back commands at column spacing give seamless bursts.
// RULE12 - Controller keeps read-to-calibration spacing around array reads.
// RULE13 - Calibration works whatever bank or refresh state, with clock enable high.
// RULE14 - Command-to-data timing equals that of an ordinary read.
// RULE15 - Burst of sixteen beats, toggling preamble, half-clock postamble.
// RULE16 - Mask pins float only with masking and both inversions disabled.
// RULE17 - Pattern and mask registers persist across calibration commands.
`default_nettype none
`include "rdcal_consts.svh"

module rdcal_pattern_gen (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire rdcal_pkg::rdcal_cmd_type cmdPins,
  output rdcal_pkg::rdcal_pins_type pinsOut,
  output logic calBusy
);

  import rdcal_pkg::*;

  typedef struct packed {
    logic linkClkPrev;
    logic armed;
    logic [7:0] patFirst;
    logic [7:0] patSecond;
    logic [7:0] invLow;
    logic [7:0] invHigh;
    logic [7:0] modeCtrl;
    logic [7:0] ioCfg;
    logic [5:0] readLat;
    logic [`RDCAL_LAT_DEPTH-1:0] latLine;
    rdcal_phase_type phase;
    logic [3:0] beat;
    logic pending;
    logic [15:0] burstPat;
    rdcal_pins_type pins;
    logic busy;
  } rdcal_state_type;

  rdcal_state_type s_reg;
  rdcal_state_type s_next;
  logic rstN;
  rdcal_cmd_type cmdSync;

  // ==============================================================
  // Reset release and pin synchronisers
  rdcal_sync2 #(
    .WIDTH(1)
  ) u_rst_sync (
    .clk(sys_clk),
    .rstN(arst_n),
    .din(1'b1),
    .dout(rstN)
  );

  rdcal_sync2 #(
    .WIDTH($bits(rdcal_cmd_type))
  ) u_cmd_sync (
    .clk(sys_clk),
    .rstN(rstN),
    .din(cmdPins),
    .dout(cmdSync)
  );

  // ==============================================================
  // Next state
  logic rise;
  logic fall;
  logic half;
  logic startNow;
  logic fire;
  logic maskFloat;
  logic beatBit;
  logic [`RDCAL_LAT_DEPTH-1:0] shifted;
  logic [`RDCAL_LAT_DEPTH-1:0] keep;
  logic [5:0] tapIdx;

  always_comb begin
    s_next = s_reg;
    rise = cmdSync.linkClk & ~s_reg.linkClkPrev;
    fall = ~cmdSync.linkClk & s_reg.linkClkPrev;
    half = rise | fall;
    startNow = 1'b0;
    fire = 1'b0;
    shifted = s_reg.latLine;
    tapIdx = (s_reg.readLat == 6'h00) ? 6'h00 : s_reg.readLat - 6'h01;
    // Only positions up to the tap are kept, so a start never fires twice.
    // Raising the latency later therefore cannot revive an old start.
    keep = {`RDCAL_LAT_DEPTH{1'b1}} >> (6'h3f - tapIdx);
    s_next.linkClkPrev = cmdSync.linkClk;

    // Command fields are taken at mid cycle, where the controller holds them steady.
    if (fall) begin
      if (cmdSync.cke) begin // RULE13
        case (cmdSync.code)
          CMD_MRW: begin
            s_next.armed = 1'b0;
            case (cmdSync.addr)
              `RDCAL_MR_PAT_FIRST: s_next.patFirst = cmdSync.op;
              `RDCAL_MR_PAT_SECOND: s_next.patSecond = cmdSync.op;
              `RDCAL_MR_INV_LOW: s_next.invLow = cmdSync.op;
              `RDCAL_MR_INV_HIGH: s_next.invHigh = cmdSync.op;
              `RDCAL_MR_MODE_CONTROL: s_next.modeCtrl = cmdSync.op;
              `RDCAL_MR_IO_CONFIG: s_next.ioCfg = cmdSync.op;
              `RDCAL_MR_READ_LATENCY: s_next.readLat = cmdSync.op[5:0];
              default: s_next.armed = 1'b0;
            endcase
          end
          CMD_CAL: s_next.armed = 1'b1;
          CMD_CAS2: begin
            // A second cycle only starts a burst straight after the calibration command.
            startNow = s_reg.armed && (cmdSync.op == 8'h00); // RULE9 RULE10
            s_next.armed = 1'b0;
          end
          default: s_next.armed = 1'b0;
        endcase
      end else begin
        s_next.armed = 1'b0;
      end
      // The start travels down a line clocked by the link and taps at the read latency.
      // A start that has passed the tap is dropped and no longer holds busy high.
      shifted = {s_reg.latLine[`RDCAL_LAT_DEPTH-2:0], startNow} & keep;
      s_next.latLine = shifted;
      fire = shifted[tapIdx]; // RULE2 RULE14
    end

    // ==============================================================
    // Burst sequencing, one step per half clock of the link
    if (half) begin
      unique case (s_reg.phase)
        PH_IDLE, PH_POST: begin
          if (fire) begin
            s_next.phase = PH_PRE;
            s_next.beat = 4'h0;
          end else begin
            s_next.phase = PH_IDLE;
          end
        end
        PH_PRE: begin
          if (fire) begin
            s_next.pending = 1'b1;
          end
          if (s_reg.beat == {2'h0, `RDCAL_PRE_HALVES} - 4'h1) begin // RULE15
            s_next.phase = PH_DATA;
            s_next.beat = 4'h0;
            s_next.burstPat = {s_reg.patSecond, s_reg.patFirst}; // RULE1 RULE17
          end else begin
            s_next.beat = s_reg.beat + 4'h1;
          end
        end
        PH_DATA: begin
          if (s_reg.beat == `RDCAL_BURST_LAST) begin // RULE15
            if (s_reg.pending || fire) begin
              s_next.beat = 4'h0; // RULE11
              s_next.pending = 1'b0;
              s_next.burstPat = {s_reg.patSecond, s_reg.patFirst};
            end else begin
              s_next.phase = PH_POST;
            end
          end else begin
            s_next.beat = s_reg.beat + 4'h1;
            if (fire) begin
              s_next.pending = 1'b1; // RULE11
            end
          end
        end
      endcase
    end

    // ==============================================================
    // Pin drive derived from the coming phase
    beatBit = s_next.burstPat[s_next.beat]; // RULE3
    maskFloat = s_next.modeCtrl[`RDCAL_DM_DISABLE_BIT] && !s_next.ioCfg[`RDCAL_WR_INV_BIT]
      && !s_next.ioCfg[`RDCAL_RD_INV_BIT];
    s_next.pins.dq = {16{beatBit}} ^ {s_next.invHigh, s_next.invLow}; // RULE5 RULE6
    s_next.pins.mask = {2{beatBit}}; // RULE7 RULE8
    s_next.pins.dqOe = (s_next.phase == PH_DATA);
    s_next.pins.maskOe = {2{(s_next.phase == PH_DATA) && !maskFloat}}; // RULE16
    s_next.pins.strobeOe = (s_next.phase != PH_IDLE);
    s_next.pins.strobe = (s_next.phase != PH_POST) && (s_next.phase != PH_IDLE)
      && !s_next.beat[0]; // RULE15
    // Busy covers a start on its way to the tap, a queued burst and the burst itself.
    s_next.busy = (s_next.phase != PH_IDLE) || (s_next.latLine != '0) || s_next.pending;
  end

  // ==============================================================
  // State register
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      s_reg <= '0;
      s_reg.patFirst <= `RDCAL_RST_PAT_FIRST; // RULE4
      s_reg.patSecond <= `RDCAL_RST_PAT_SECOND; // RULE4
      s_reg.invLow <= `RDCAL_RST_INV_LOW; // RULE4
      s_reg.invHigh <= `RDCAL_RST_INV_HIGH; // RULE4
      s_reg.modeCtrl <= `RDCAL_RST_MODE_CONTROL;
      s_reg.ioCfg <= `RDCAL_RST_IO_CONFIG;
      s_reg.readLat <= `RDCAL_RST_READ_LATENCY;
      s_reg.phase <= PH_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pinsOut = s_reg.pins;
  assign calBusy = s_reg.busy;

endmodule

`default_nettype wire

// >>> rdcal_consts.svh
// Constants for the read calibration pattern generator.
`ifndef RDCAL_CONSTS_SVH
`define RDCAL_CONSTS_SVH

// Command codes on the decoded command port.
`define RDCAL_CMD_DESELECT 3'h0
`define RDCAL_CMD_MRW 3'h1
`define RDCAL_CMD_CAL 3'h2
`define RDCAL_CMD_CAS2 3'h3
`define RDCAL_CMD_OTHER 3'h4

// Mode register addresses carried with a mode register write.
`define RDCAL_MR_IO_CONFIG 6'h03
`define RDCAL_MR_READ_LATENCY 6'h02
`define RDCAL_MR_MODE_CONTROL 6'h0d
`define RDCAL_MR_INV_LOW 6'h0f
`define RDCAL_MR_INV_HIGH 6'h14
`define RDCAL_MR_PAT_FIRST 6'h20
`define RDCAL_MR_PAT_SECOND 6'h28

// Reset values.
`define RDCAL_RST_PAT_FIRST 8'h5a
`define RDCAL_RST_PAT_SECOND 8'h3c
`define RDCAL_RST_INV_LOW 8'h55
`define RDCAL_RST_INV_HIGH 8'h55
`define RDCAL_RST_MODE_CONTROL 8'h00
`define RDCAL_RST_IO_CONFIG 8'h00
`define RDCAL_RST_READ_LATENCY 6'h06

// Field positions.
`define RDCAL_DM_DISABLE_BIT 5
`define RDCAL_WR_INV_BIT 7
`define RDCAL_RD_INV_BIT 6

// Burst shape in half clocks of the link; latency line depth in link clocks.
`define RDCAL_PRE_HALVES 2'h2
`define RDCAL_BURST_LAST 4'hf
`define RDCAL_LAT_DEPTH 64

`endif

// >>> rdcal_pkg.sv
// Types shared by the read calibration pattern generator.
`default_nettype none
`include "rdcal_consts.svh"

package rdcal_pkg;

  typedef enum logic [2:0] {
    CMD_DESELECT = `RDCAL_CMD_DESELECT,
    CMD_MRW = `RDCAL_CMD_MRW,
    CMD_CAL = `RDCAL_CMD_CAL,
    CMD_CAS2 = `RDCAL_CMD_CAS2,
    CMD_OTHER = `RDCAL_CMD_OTHER
  } rdcal_cmd_code_type;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_PRE = 2'h1,
    PH_DATA = 2'h3,
    PH_POST = 2'h2
  } rdcal_phase_type;

  typedef struct packed {
    logic linkClk;
    logic cke;
    rdcal_cmd_code_type code;
    logic [5:0] addr;
    logic [7:0] op;
  } rdcal_cmd_type;

  typedef struct packed {
    logic [15:0] dq;
    logic dqOe;
    logic [1:0] mask;
    logic [1:0] maskOe;
    logic strobe;
    logic strobeOe;
  } rdcal_pins_type;

endpackage

`default_nettype wire

// >>> rdcal_sync2.sv
// Two flip-flop synchroniser for a group of levels.
`default_nettype none

module rdcal_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } rdcal_sync_state_type;

  rdcal_sync_state_type s_reg;
  rdcal_sync_state_type s_next;

  always_comb begin
    s_next.first = din;
    s_next.second = s_reg.first;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.second;

endmodule

`default_nettype wire

// >>> rdcal_pattern_gen_properties.sv
// Port-level checks for the read calibration pattern generator.
`default_nettype none
module rdcal_pattern_gen_properties (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire rdcal_pkg::rdcal_cmd_type cmdPins,
  input wire rdcal_pkg::rdcal_pins_type pinsOut,
  input wire logic calBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  import rdcal_pkg::*;
  wire logic dOe = pinsOut.dqOe;
  wire logic sOe = pinsOut.strobeOe;
  wire logic st = pinsOut.strobe;
  logic [8:0] runCount_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Counts the cycles the data pins have been driven in one stretch.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      runCount_reg <= 9'h0;
    end else begin
      runCount_reg <= dOe ? runCount_reg + 9'h1 : 9'h0;
    end
  end
  a_strobe_with_data: assert property (dOe |-> sOe)
    else $error("data driven without strobe");
  a_mask_needs_data: assert property (|pinsOut.maskOe |-> dOe)
    else $error("mask pins driven outside data");
  a_mask_pair_same: assert property (pinsOut.maskOe[0] |->
    pinsOut.maskOe[1] && pinsOut.mask[0] == pinsOut.mask[1])
    else $error("mask pins differ");
  a_preamble_lead: assert property ($rose(dOe) |-> $past(sOe, 15))
    else $error("preamble too short");
  a_preamble_toggle: assert property ($rose(sOe) |-> st[*7] ##[1:2] !st)
    else $error("preamble strobe wrong");
  a_postamble_half: assert property ($fell(dOe) |-> (sOe && !st)[*7] ##[1:3] !sOe)
    else $error("postamble wrong");
  a_beat_hold: assert property ($past(dOe) && dOe && $stable(st) |-> $stable(pinsOut.dq))
    else $error("data changed within a beat");
  a_burst_sixteen: assert property ($fell(dOe) |->
    runCount_reg[6:0] == 7'h0 && runCount_reg != 9'h0)
    else $error("burst not sixteen beats");
  a_busy_covers: assert property (sOe |-> calBusy)
    else $error("burst while not busy");
endmodule
bind rdcal_pattern_gen rdcal_pattern_gen_properties u_props (.sys_clk(sys_clk),
  .arst_n(arst_n), .cmdPins(cmdPins), .pinsOut(pinsOut), .calBusy(calBusy));
`default_nettype wire

// >>> rdcal_ctrl_model.sv
// Controller model: free running link clock and command cycles.
`default_nettype none
module rdcal_ctrl_model (
  input wire logic cke,
  output var rdcal_pkg::rdcal_cmd_type cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  import rdcal_pkg::*;
  time tCas = 0;
  initial begin
    cmd = '0;
    #10;
    forever #80 cmd.linkClk = ~cmd.linkClk;
  end
  task automatic send(input rdcal_cmd_code_type c, input logic [5:0] a, input logic [7:0] o);
    @(posedge cmd.linkClk);
    cmd.cke = cke;
    cmd.code = c;
    cmd.addr = a;
    cmd.op = o;
  endtask
  // The second cycle follows at once with all operands low; no array read is ever sent.
  task automatic calPair();
    send(CMD_CAL, 6'h00, 8'h00);
    send(CMD_CAS2, 6'h00, 8'h00);
    tCas = $time;
    send(CMD_DESELECT, 6'h00, 8'h00);
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the read calibration pattern generator.
`default_nettype none
`include "rdcal_consts.svh"
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin nFail++; \
  $display("mismatch %0t %h %h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rdcal_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ke = 1'b1;
  rdcal_cmd_type cmdPins;
  rdcal_pins_type pinsOut;
  logic calBusy;
  int nFail = 0;
  int samplesChecked = 0;
  time lat;
  time latA;
  rdcal_ctrl_model u_ctrl (.cke(ke), .cmd(cmdPins));
  rdcal_pattern_gen u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .cmdPins(cmdPins),
    .pinsOut(pinsOut), .calBusy(calBusy));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    u_ctrl.send(CMD_MRW, a, v);
  endtask
  // Waits until the strobe of an earlier burst has been released.
  task automatic waitIdle();
    int w;
    w = 0;
    while (pinsOut.strobeOe !== 1'b0 && w < 400) begin
      @(negedge sys_clk);
      w++;
    end
    if (w == 400) begin
      nFail++;
      summarize();
    end
  endtask
  // Waits for a burst and checks n beats sampled in the middle of each beat.
  task automatic burst(input logic [15:0] pat, input logic [15:0] inv, input logic [1:0] moe,
    input int n);
    int w;
    waitIdle();
    w = 0;
    while (pinsOut.strobeOe !== 1'b1 && w < 400) begin
      @(negedge sys_clk);
      w++;
    end
    if (w == 400) begin
      nFail++;
      summarize();
    end else begin
      lat = $time - u_ctrl.tCas;
      `CHK(calBusy, 1'b1)
      #200;
      for (int k = 0; k < n; k++) begin
        `CHK({pinsOut.dqOe, pinsOut.strobe}, {1'b1, !k[0]})
        `CHK(pinsOut.dq, {16{pat[k % 16]}} ^ inv)
        `CHK(pinsOut.maskOe, moe)
        `CHK(pinsOut.mask & moe, {2{pat[k % 16]}} & moe)
        #80;
      end
    end
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    fork
      u_ctrl.calPair();
      burst(16'h3c5a, 16'h5555, 2'h3, 16);
    join
    latA = lat;
    $display("test defaults done");
    wr(`RDCAL_MR_PAT_FIRST, 8'h1c);
    wr(`RDCAL_MR_PAT_SECOND, 8'h59);
    wr(`RDCAL_MR_INV_LOW, 8'h0f);
    wr(`RDCAL_MR_INV_HIGH, 8'ha0);
    wr(`RDCAL_MR_MODE_CONTROL, 8'h20);
    wr(`RDCAL_MR_READ_LATENCY, 8'h04);
    for (int j = 0; j < 4; j++) begin
      wr(`RDCAL_MR_IO_CONFIG, 8'(j << 6));
      fork
        u_ctrl.calPair();
        burst(16'h591c, 16'ha00f, (j != 0) ? 2'h3 : 2'h0, 16);
      join
    end
    `CHK(latA - lat, 320)
    $display("test modes done");
    fork
      begin
        u_ctrl.calPair();
        repeat (5) u_ctrl.send(CMD_DESELECT, 6'h00, 8'h00);
        u_ctrl.calPair();
      end
      burst(16'h591c, 16'ha00f, 2'h3, 32);
    join
    $display("test seamless done");
    waitIdle();
    fork
      begin
        u_ctrl.send(CMD_CAS2, 6'h00, 8'h00);
        u_ctrl.send(CMD_CAL, 6'h00, 8'h00);
        u_ctrl.send(CMD_CAS2, 6'h00, 8'h01);
        ke = 1'b0;
        u_ctrl.calPair();
        ke = 1'b1;
      end
      repeat (250) begin
        @(negedge sys_clk);
        `CHK({pinsOut.strobeOe, calBusy}, 2'h0)
      end
    join
    $display("test refusals done");
    summarize();
  end
endmodule
`default_nettype wire
